// >>> rtl/rtc_locked_indirect_access.sv
`timescale 1ns/1ns
`include "rtc_access_map.svh"
module rtc_locked_indirect_access
   import rtc_access_pkg::*;
(
   input wire logic ref_clk,          // system clock, 10 MHz
   input wire logic reset_n,          // synchronous reset, active low
   input wire logic [7:0] sfrAddr,    // register address
   input wire logic sfrWr,            // write strobe
   input wire logic sfrRd,            // read strobe
   input wire logic [7:0] sfrWrData,  // write data
   output logic [7:0] sfrRdData       // registered read data
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   lock_state_t lock_reg, lock_next;
   xfer_state_t xfer_reg, xfer_next;
   logic autoread_enable_reg, autoread_enable_next;
   logic short_reg, short_next;
   logic [3:0] addr_reg, addr_next;
   logic [7:0] data_reg, data_next;
   logic [3:0] cnt_reg, cnt_next;
   logic isWrite_reg, isWrite_next;
   logic [7:0] rdOut_next;
   logic memWr;
   logic [7:0] memRd;
   logic [7:0] lockVal;
   localparam logic [7:0] ctrlResetVal = `ADDR_CTRL_RESET;
   logic wrKey, wrAdr, wrDat, rdDat, accessOk, startRd, startWr, lastCycle;

   assign wrKey = sfrWr && sfrAddr == `KEY_OFS;
   assign wrAdr = sfrWr && sfrAddr == `ADDR_CTRL_OFS;
   assign wrDat = sfrWr && sfrAddr == `DATA_OFS;
   assign rdDat = sfrRd && sfrAddr == `DATA_OFS;
   assign accessOk = lock_reg == UNLOCKED;
   assign lastCycle = xfer_reg == XFER_RUN && cnt_reg == 4'h1;
   assign startRd = accessOk && xfer_reg == XFER_IDLE &&
      ((wrAdr && sfrWrData[`BUSY_BIT]) || (rdDat && autoread_enable_reg)); // autoread relaunch
   assign startWr = accessOk && xfer_reg == XFER_IDLE && wrDat;
   assign memWr = lastCycle && isWrite_reg;

   always_comb begin
      case (lock_reg)
         LOCKED: lockVal = `LOCK_VAL_LOCKED;
         WAIT_SECOND: lockVal = `LOCK_VAL_WAIT;
         UNLOCKED: lockVal = `LOCK_VAL_OPEN;
         DISABLED: lockVal = `LOCK_VAL_DISABLED;
         default: lockVal = `LOCK_VAL_DISABLED;
      endcase
   end

   // ------------------------------------------------------------
   // lock and key
   // ------------------------------------------------------------
   always_comb begin
      lock_next = lock_reg;
      case (lock_reg)
         LOCKED: begin
            // wrong first key or locked access
            if ((wrKey && sfrWrData != `FIRST_KEY) || wrAdr || wrDat || rdDat) begin
               lock_next = DISABLED;
            end else if (wrKey) begin
               lock_next = WAIT_SECOND;
            end
         end
         WAIT_SECOND: begin
            if (wrKey && sfrWrData == `SECOND_KEY) begin
               lock_next = UNLOCKED;
            end else if (wrKey || wrAdr || wrDat || rdDat) begin
               lock_next = DISABLED;
            end
         end
         UNLOCKED: begin
            if (wrKey) begin
               lock_next = LOCKED;
            end
         end
         DISABLED: lock_next = DISABLED;
         default: lock_next = DISABLED;
      endcase
   end

   // ------------------------------------------------------------
   // indirect transfer engine
   // ------------------------------------------------------------
   always_comb begin
      xfer_next = xfer_reg;
      cnt_next = cnt_reg;
      isWrite_next = isWrite_reg;
      autoread_enable_next = autoread_enable_reg;
      short_next = short_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      // busy transfers lock out control writes to avoid retargeting midway
      if (accessOk && wrAdr && xfer_reg == XFER_IDLE) begin
         autoread_enable_next = sfrWrData[`AUTOREAD_ENABLE_BIT];
         short_next = sfrWrData[`SHORT_BIT];
         addr_next = sfrWrData[`ADDR_MSB:0];
      end
      if (accessOk && wrDat && xfer_reg == XFER_IDLE) begin
         data_next = sfrWrData;
      end
      case (xfer_reg)
         XFER_IDLE: begin
            if (startRd || startWr) begin
               xfer_next = XFER_RUN;
               isWrite_next = startWr;
               if (wrAdr ? sfrWrData[`SHORT_BIT] : short_reg) begin
                  cnt_next = `XFER_CYCLES_SHORT;
               end else begin
                  cnt_next = `XFER_CYCLES_NORMAL;
               end
            end
         end
         XFER_RUN: begin
            cnt_next = cnt_reg - 4'h1;
            if (lastCycle) begin
               xfer_next = XFER_IDLE;
               if (!isWrite_reg) begin
                  data_next = memRd;
               end
               if (addr_reg <= `CAPTURE_LAST ||
                   (addr_reg >= `ALARM_FIRST && addr_reg <= `ALARM_LAST)) begin
                  addr_next = addr_reg + 4'h1;
               end
            end
         end
         default: xfer_next = XFER_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always_comb begin
      rdOut_next = sfrRdData;
      if (sfrRd) begin
         case (sfrAddr)
            `KEY_OFS: rdOut_next = lockVal;
            `ADDR_CTRL_OFS: rdOut_next = accessOk ?
               {xfer_reg == XFER_RUN, autoread_enable_reg, 1'b0, short_reg, addr_reg} : 8'h00;
            `DATA_OFS: rdOut_next = accessOk ? data_reg : 8'h00;
            default: rdOut_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         lock_reg <= LOCKED;
         xfer_reg <= XFER_IDLE;
         cnt_reg <= 4'h0;
         isWrite_reg <= 1'b0;
         autoread_enable_reg <= ctrlResetVal[`AUTOREAD_ENABLE_BIT];
         short_reg <= ctrlResetVal[`SHORT_BIT];
         addr_reg <= ctrlResetVal[`ADDR_MSB:0];
         data_reg <= `DATA_RESET;
         sfrRdData <= 8'h00;
      end else begin
         lock_reg <= lock_next;
         xfer_reg <= xfer_next;
         cnt_reg <= cnt_next;
         isWrite_reg <= isWrite_next;
         autoread_enable_reg <= autoread_enable_next;
         short_reg <= short_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
         sfrRdData <= rdOut_next;
      end
   end

   // capture and alarm bytes in bank
   rtc_internal_regs #(.DEPTH(`INT_REG_COUNT)) u_regs (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .wrEn(memWr),
      .addr(addr_reg),
      .wrData(data_reg),
      .rdData(memRd)
   );

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_disabled_sticks: assert property (@(posedge ref_clk) disable iff (!reset_n)
      lock_reg == DISABLED |=> lock_reg == DISABLED) else $error("left disabled state");
   a_unlock_seq: assert property (@(posedge ref_clk) disable iff (!reset_n)
      lock_reg == WAIT_SECOND && wrKey && sfrWrData == `SECOND_KEY |=> lock_reg == UNLOCKED)
      else $error("second key did not unlock");
   a_bad_second: assert property (@(posedge ref_clk) disable iff (!reset_n)
      lock_reg == WAIT_SECOND && wrKey && sfrWrData != `SECOND_KEY |=> lock_reg == DISABLED)
      else $error("bad second key not disabled");
   a_relock: assert property (@(posedge ref_clk) disable iff (!reset_n)
      lock_reg == UNLOCKED && wrKey |=> lock_reg == LOCKED) else $error("key write did not relock");
   a_locked_access: assert property (@(posedge ref_clk) disable iff (!reset_n)
      lock_reg == LOCKED && (wrAdr || wrDat) |=> lock_reg == DISABLED) else $error("locked access allowed");
   a_busy_normal: assert property (@(posedge ref_clk) disable iff (!reset_n)
      xfer_reg == XFER_IDLE && (startRd || startWr) && cnt_next == `XFER_CYCLES_NORMAL
      |=> (xfer_reg == XFER_RUN) [*7] ##1 xfer_reg == XFER_IDLE) else $error("normal length wrong");
   a_busy_short: assert property (@(posedge ref_clk) disable iff (!reset_n)
      xfer_reg == XFER_IDLE && (startRd || startWr) && cnt_next == `XFER_CYCLES_SHORT
      |=> (xfer_reg == XFER_RUN) [*6] ##1 xfer_reg == XFER_IDLE) else $error("short length wrong");
   a_status_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
      sfrRd && sfrAddr == `KEY_OFS |=> sfrRdData == $past(lockVal)) else $error("status read wrong");
   a_addr_incr: assert property (@(posedge ref_clk) disable iff (!reset_n)
      lastCycle && addr_reg <= `CAPTURE_LAST |=> addr_reg == $past(addr_reg) + 4'h1)
      else $error("address not incremented");
   a_unused_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
      sfrRd && sfrAddr == `ADDR_CTRL_OFS |=> sfrRdData[`UNUSED_BIT] == 1'b0) else $error("bit 5 nonzero");
endmodule

// >>> rtl/rtc_access_map.svh
`ifndef RTC_ACCESS_MAP_SVH
`define RTC_ACCESS_MAP_SVH
// ------------------------------------------------------------
// special-function register addresses
// ------------------------------------------------------------
`define ADDR_CTRL_OFS 8'hac
`define DATA_OFS 8'had
`define KEY_OFS 8'hae
// ------------------------------------------------------------
// key codes and lock state values
// ------------------------------------------------------------
`define FIRST_KEY 8'ha5
`define SECOND_KEY 8'hf1
`define LOCK_VAL_LOCKED 8'h00
`define LOCK_VAL_WAIT 8'h01
`define LOCK_VAL_OPEN 8'h02
`define LOCK_VAL_DISABLED 8'h03
// ------------------------------------------------------------
// address/control fields
// ------------------------------------------------------------
`define BUSY_BIT 7
`define AUTOREAD_ENABLE_BIT 6
`define UNUSED_BIT 5
`define SHORT_BIT 4
`define ADDR_MSB 3
`define ADDR_CTRL_RESET 8'h00
`define DATA_RESET 8'h00
// ------------------------------------------------------------
// transfer timing and internal map
// ------------------------------------------------------------
`define XFER_CYCLES_NORMAL 4'h7
`define XFER_CYCLES_SHORT 4'h6
`define CAPTURE_LAST 4'h3
`define ALARM_FIRST 4'h8
`define ALARM_LAST 4'hb
`define INT_REG_COUNT 12
`endif

// >>> rtl/rtc_access_pkg.sv
package rtc_access_pkg;
   typedef enum logic [3:0] {
      LOCKED = 4'h1,
      WAIT_SECOND = 4'h2,
      UNLOCKED = 4'h4,
      DISABLED = 4'h8
   } lock_state_t;
   typedef enum logic [1:0] {
      XFER_IDLE = 2'h1,
      XFER_RUN = 2'h2
   } xfer_state_t;
endpackage

// >>> rtl/rtc_internal_regs.sv
`timescale 1ns/1ns
`include "rtc_access_map.svh"
// ------------------------------------------------------------
// clock-domain register bank, read data registered
// ------------------------------------------------------------
module rtc_internal_regs #(
   parameter int DEPTH = `INT_REG_COUNT
) (
   input wire logic ref_clk,          // system clock
   input wire logic reset_n,          // synchronous reset
   input wire logic wrEn,             // one-cycle write strobe
   input wire logic [3:0] addr,       // entry index
   input wire logic [7:0] wrData,     // byte to store
   output logic [7:0] rdData          // registered read byte
);
   logic [7:0] mem_reg [DEPTH];
   logic [7:0] rd_next;

   always_comb begin
      rd_next = 8'h00;
      if (int'(addr) < DEPTH) begin
         rd_next = mem_reg[addr];
      end
   end

   // contents survive reset, as the timekeeping domain does
   always_ff @(posedge ref_clk) begin
      if (wrEn && int'(addr) < DEPTH) begin
         mem_reg[addr] <= wrData;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rdData <= 8'h00;
      end else begin
         rdData <= rd_next;
      end
   end
endmodule

// >>> verif/sfr_core_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// processor-side register access model
// ------------------------------------------------------------
module sfr_core_model (
   input wire logic ref_clk,          // system clock
   input wire logic [7:0] sfrRdData,  // read data from the port
   output logic [7:0] sfrAddr,        // register address
   output logic sfrWr,                // write strobe
   output logic sfrRd,                // read strobe
   output logic [7:0] sfrWrData       // write data
);
   initial begin
      sfrAddr = 8'h00;
      sfrWr = 1'b0;
      sfrRd = 1'b0;
      sfrWrData = 8'h00;
   end
   // plain moves only
   // entered at a falling edge; one strobe cycle, then one idle cycle
   task automatic access(input logic isWr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      sfrAddr = a;
      sfrWrData = d;
      sfrWr = isWr;
      sfrRd = !isWr;
      @(negedge ref_clk);
      q = sfrRdData;
      sfrWr = 1'b0;
      sfrRd = 1'b0;
      // released bus shows the inverse, never a stale copy
      sfrAddr = ~a;
      sfrWrData = ~d;
      @(negedge ref_clk);
   endtask
endmodule

// >>> verif/rtc_locked_indirect_access_tb.sv
`timescale 1ns/1ns
`include "rtc_access_map.svh"
module rtc_locked_indirect_access_tb;
   typedef struct {logic isWr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   logic ref_clk;
   logic reset_n;
   logic [7:0] sfrAddr;
   logic sfrWr;
   logic sfrRd;
   logic [7:0] sfrWrData;
   logic [7:0] sfrRdData;
   logic [7:0] q;
   int bad_count = 0;
   int checks = 0;
   row_t rows [11];
   sfr_core_model core (.ref_clk(ref_clk), .sfrRdData(sfrRdData), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
      .sfrRd(sfrRd), .sfrWrData(sfrWrData));
   rtc_locked_indirect_access uut (.ref_clk(ref_clk), .reset_n(reset_n), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
      .sfrRd(sfrRd), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic do_reset;
      reset_n = 1'b0;
      repeat (12) @(negedge ref_clk);
      reset_n = 1'b1;
   endtask
   task automatic rd_after(input int m, input logic [7:0] a);
      repeat (m) @(negedge ref_clk);
      core.access(1'b0, a, 8'h00, q);
   endtask
   // write at the launch edge, busy sampled at the seventh edge after it
   task automatic xfer(input logic [7:0] ctrl, input logic [7:0] d, input logic busy, input logic [7:0] adr);
      core.access(1'b1, `ADDR_CTRL_OFS, ctrl, q);
      core.access(1'b1, `DATA_OFS, d, q);
      rd_after(5, `ADDR_CTRL_OFS);
      chk("busy bit", {7'h00, busy}, {7'h00, q[`BUSY_BIT]});
      rd_after(4, `ADDR_CTRL_OFS);
      chk("address field", adr, q);
   endtask
   // watchdog: the whole sequence needs well under 1000 cycles
   initial begin
      #(3000 * 100);
      bad_count++;
      end_of_test;
   end
   initial begin
      reset_n = 1'b0;
      rows = '{
         '{1'b0, `KEY_OFS, 8'h00, `LOCK_VAL_LOCKED},
         '{1'b1, `KEY_OFS, `FIRST_KEY, 8'h00},
         '{1'b0, `KEY_OFS, 8'h00, `LOCK_VAL_WAIT},
         '{1'b0, `KEY_OFS, 8'h00, `LOCK_VAL_WAIT},
         '{1'b1, `KEY_OFS, `SECOND_KEY, 8'h00},
         '{1'b0, `KEY_OFS, 8'h00, `LOCK_VAL_OPEN},
         '{1'b0, `ADDR_CTRL_OFS, 8'h00, 8'h00},
         '{1'b0, `DATA_OFS, 8'h00, 8'h00},
         '{1'b1, `ADDR_CTRL_OFS, 8'h25, 8'h00},
         '{1'b0, `ADDR_CTRL_OFS, 8'h00, 8'h05},
         '{1'b0, 8'haa, 8'h00, 8'h00}};
      do_reset;
      foreach (rows[i]) begin
         core.access(rows[i].isWr, rows[i].a, rows[i].d, q);
         if (!rows[i].isWr) begin
            chk("table read", rows[i].e, q);
         end
      end
      xfer(8'h00, 8'h11, 1'b1, 8'h01);
      xfer(8'h11, 8'h22, 1'b0, 8'h12);
      xfer(8'h08, 8'h33, 1'b1, 8'h09);
      xfer(8'h0b, 8'h44, 1'b1, 8'h0c);
      xfer(8'h05, 8'h66, 1'b1, 8'h05);
      // second data write lands while busy and must be dropped
      core.access(1'b1, `DATA_OFS, 8'h99, q);
      core.access(1'b1, `DATA_OFS, 8'h5a, q);
      rd_after(10, `DATA_OFS);
      core.access(1'b1, `ADDR_CTRL_OFS, 8'h85, q);
      rd_after(10, `DATA_OFS);
      chk("write during busy", 8'h99, q);
      core.access(1'b1, `ADDR_CTRL_OFS, 8'hc0, q);
      rd_after(10, `DATA_OFS);
      chk("autoread byte 0", 8'h11, q);
      rd_after(10, `DATA_OFS);
      chk("autoread byte 1", 8'h22, q);
      rd_after(10, `ADDR_CTRL_OFS);
      chk("autoread address", 8'h43, q);
      core.access(1'b1, `KEY_OFS, 8'h3c, q);
      rd_after(0, `KEY_OFS);
      chk("relock", `LOCK_VAL_LOCKED, q);
      rd_after(0, `ADDR_CTRL_OFS);
      chk("locked address read", 8'h00, q);
      core.access(1'b1, `ADDR_CTRL_OFS, 8'h80, q);
      rd_after(0, `KEY_OFS);
      chk("access while locked", `LOCK_VAL_DISABLED, q);
      core.access(1'b1, `KEY_OFS, `FIRST_KEY, q);
      core.access(1'b1, `KEY_OFS, `SECOND_KEY, q);
      rd_after(0, `KEY_OFS);
      chk("keys while disabled", `LOCK_VAL_DISABLED, q);
      for (int k = 0; k < 2; k++) begin
         do_reset;
         if (k == 1) begin
            core.access(1'b1, `KEY_OFS, `FIRST_KEY, q);
         end
         core.access(1'b1, `KEY_OFS, 8'h12, q);
         rd_after(0, `KEY_OFS);
         chk("wrong key", `LOCK_VAL_DISABLED, q);
      end
      do_reset;
      core.access(1'b1, `KEY_OFS, `FIRST_KEY, q);
      core.access(1'b1, `KEY_OFS, `SECOND_KEY, q);
      rd_after(0, `KEY_OFS);
      chk("unlock after reset", `LOCK_VAL_OPEN, q);
      rd_after(0, `ADDR_CTRL_OFS);
      chk("address after reset", `ADDR_CTRL_RESET, q);
      end_of_test;
   end
endmodule
